// File: amvc_level_output_bank.sv
// Level, silence and output stage configuration bank with gradual level ramp
//
// Overview of operation
// [RULE_01] Ramp enable bit 7 of register 0x03, set enables gradual level change, resets one.
// [RULE_02] Bits 6:2 of register 0x03 read zero; host leaves them at default.
// [RULE_03] Bit 1 silences right channel, outputs idle at half duty, clear restores.
// [RULE_04] Bit 0 silences left channel, outputs idle at half duty, clear restores.
// [RULE_05] Left level code in half-dB steps: ff=+24, cf=0 (reset), 07=-100 dB.
// [RULE_06] Right level code uses same mapping, resets to cf.
// [RULE_07] Level codes below 07 silence the channel fully.
// [RULE_08] Bit 7 of 0x06 picks bridge-tied (0) or parallel-bridge (1), resets zero.
// [RULE_09] Field 6:4 selects switching multiple 6,8,10,12,14,16,20,24; resets 101.
// [RULE_10] Multiples hold in single speed; double speed halves the switching rate.
// [RULE_11] Field 3:2 selects analog gain, reset 00; code 11 is never written.
// [RULE_12] Bit 1 picks mono source in parallel-bridge: 0 right, 1 left.
// [RULE_13] Bit 0 of 0x06 is reserved read/write, resets one.
// [RULE_14] Speed mode select: clear single-speed rates, set double-speed rates.
// [RULE_15] With ramping on, level and silence changes step gradually.
`timescale 1ns/1ns
`include "amvc_consts.svh"

module amvc_level_output_bank
   import amvc_pkg::*;
#(
   parameter int unsigned RAMP_STEP_CYC = `AMVC_RAMP_STEP_CYC
) (
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_n,
   input  wire logic [`AMVC_ADDR_W-1:0]  i_reg_addr,
   input  wire logic                     i_reg_wr,
   input  wire logic                     i_reg_rd,
   input  wire logic [7:0]               i_reg_wdata,
   output logic      [7:0]               o_reg_rdata,
   output logic                          o_reg_rvalid,
   input  wire logic                     i_speed_mode_select,
   output logic      [7:0]               o_left_applied_level,
   output logic      [7:0]               o_right_applied_level,
   output logic                          o_left_silenced,
   output logic                          o_right_silenced,
   output logic                          o_ramp_busy,
   output amvc_topology_t                o_parallel_bridge_mode,
   output logic                          o_mono_source_select,
   output logic      [1:0]               o_analog_gain,
   output logic      [2:0]               o_switch_rate_code,
   output logic      [5:0]               o_switch_half_multiple
);

   localparam int unsigned STEP_W = $clog2(RAMP_STEP_CYC + 1);

   logic [7:0]       ramp_silence_ff;
   logic [7:0]       left_level_ff;
   logic [7:0]       right_level_ff;
   logic [7:0]       out_stage_ff;
   logic [7:0]       nxt_rdata;
   logic [7:0]       reg_rdata_ff;
   logic             reg_rvalid_ff;
   logic [5:0]       switch_half_ff;
   logic [7:0]       target_lvl [2];
   logic [7:0]       applied_ff [2];
   logic             ramp_on;

   // Multiple of the frame sync clock for a switching-rate code
   function automatic logic [4:0] rate_multiple(input logic [2:0] code);
      logic [4:0] m;
      m = 5'd16;
      case (code)
         3'b000:  m = 5'd6;
         3'b001:  m = 5'd8;
         3'b010:  m = 5'd10;
         3'b011:  m = 5'd12;
         3'b100:  m = 5'd14;
         3'b101:  m = 5'd16;
         3'b110:  m = 5'd20;
         3'b111:  m = 5'd24;
         default: m = 5'd16;
      endcase
      return m;
   endfunction

   // Level target after the silence bit and the mute floor
   function automatic logic [7:0] level_target(input logic [7:0] code, input logic silence);
      logic [7:0] t;
      t = code;
      if (silence || (code < `AMVC_LEVEL_FLOOR)) begin // [RULE_07]
         t = `AMVC_LEVEL_SILENT;
      end
      return t;
   endfunction

   // Register writes
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ramp_silence_ff <= `AMVC_RST_RAMP_SILENCE;
      end else if (i_reg_wr && (i_reg_addr == `AMVC_OFS_RAMP_SILENCE)) begin
         // Reserved middle bits never stored, so they always read zero
         ramp_silence_ff <= i_reg_wdata & `AMVC_RS_WR_MASK; // [RULE_02]
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         left_level_ff <= `AMVC_RST_LEVEL; // [RULE_05]
      end else if (i_reg_wr && (i_reg_addr == `AMVC_OFS_LEFT_LEVEL)) begin
         left_level_ff <= i_reg_wdata; // [RULE_05]
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         right_level_ff <= `AMVC_RST_LEVEL; // [RULE_06]
      end else if (i_reg_wr && (i_reg_addr == `AMVC_OFS_RIGHT_LEVEL)) begin
         right_level_ff <= i_reg_wdata; // [RULE_06]
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         out_stage_ff <= `AMVC_RST_OUT_STAGE; // [RULE_08] [RULE_09] [RULE_13]
      end else if (i_reg_wr && (i_reg_addr == `AMVC_OFS_OUT_STAGE)) begin
         out_stage_ff[`AMVC_OS_BRIDGE_BIT] <= i_reg_wdata[`AMVC_OS_BRIDGE_BIT]; // [RULE_08]
         out_stage_ff[`AMVC_OS_RATE_HI:`AMVC_OS_RATE_LO] <=
            i_reg_wdata[`AMVC_OS_RATE_HI:`AMVC_OS_RATE_LO]; // [RULE_09]
         // Forbidden gain code is dropped so the output stage never sees it
         if (i_reg_wdata[`AMVC_OS_GAIN_HI:`AMVC_OS_GAIN_LO] != `AMVC_GAIN_FORBIDDEN) begin
            out_stage_ff[`AMVC_OS_GAIN_HI:`AMVC_OS_GAIN_LO] <=
               i_reg_wdata[`AMVC_OS_GAIN_HI:`AMVC_OS_GAIN_LO]; // [RULE_11]
         end
         out_stage_ff[`AMVC_OS_MONO_BIT] <= i_reg_wdata[`AMVC_OS_MONO_BIT]; // [RULE_12]
         out_stage_ff[`AMVC_OS_RSVD_BIT] <= i_reg_wdata[`AMVC_OS_RSVD_BIT]; // [RULE_13]
      end
   end

   // Register reads, answered one cycle after the strobe
   always_comb begin
      case (i_reg_addr)
         `AMVC_OFS_RAMP_SILENCE: nxt_rdata = ramp_silence_ff;
         `AMVC_OFS_LEFT_LEVEL:   nxt_rdata = left_level_ff;
         `AMVC_OFS_RIGHT_LEVEL:  nxt_rdata = right_level_ff;
         `AMVC_OFS_OUT_STAGE:    nxt_rdata = out_stage_ff;
         default:                nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         reg_rdata_ff  <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= i_reg_rd;
         if (i_reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   // Switching rate in half multiples of the frame sync clock
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         switch_half_ff <= `AMVC_RST_SWITCH_HALF;
      end else if (i_speed_mode_select) begin // [RULE_14]
         switch_half_ff <= {1'b0, rate_multiple(out_stage_ff[`AMVC_OS_RATE_HI:`AMVC_OS_RATE_LO])}; // [RULE_10]
      end else begin
         switch_half_ff <= {rate_multiple(out_stage_ff[`AMVC_OS_RATE_HI:`AMVC_OS_RATE_LO]), 1'b0}; // [RULE_09]
      end
   end

   assign ramp_on       = ramp_silence_ff[`AMVC_RS_RAMP_BIT]; // [RULE_01]
   assign target_lvl[0] = level_target(left_level_ff, ramp_silence_ff[`AMVC_RS_SIL_L_BIT]); // [RULE_04]
   assign target_lvl[1] = level_target(right_level_ff, ramp_silence_ff[`AMVC_RS_SIL_R_BIT]); // [RULE_03]

   // One ramp engine per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
      amvc_ramp_state_t    state_ff;
      logic [STEP_W-1:0]   wait_ff;

      always_ff @(posedge i_ref_clk) begin
         if (!i_rst_n) begin
            state_ff      <= AMVC_RAMP_IDLE;
            wait_ff       <= '0;
            applied_ff[ch] <= `AMVC_RST_LEVEL;
         end else if (!ramp_on) begin
            state_ff       <= AMVC_RAMP_IDLE;
            wait_ff        <= '0;
            applied_ff[ch] <= target_lvl[ch]; // [RULE_01]
         end else begin
            case (state_ff)
               AMVC_RAMP_IDLE: begin
                  if (applied_ff[ch] != target_lvl[ch]) begin
                     state_ff <= AMVC_RAMP_WAIT;
                     wait_ff  <= '0;
                  end
               end
               AMVC_RAMP_WAIT: begin
                  if (wait_ff == STEP_W'(RAMP_STEP_CYC - 1)) begin
                     state_ff <= AMVC_RAMP_STEP;
                  end else begin
                     wait_ff <= wait_ff + 1'b1;
                  end
               end
               AMVC_RAMP_STEP: begin
                  // One half-dB code per step toward the target
                  if (applied_ff[ch] < target_lvl[ch]) begin
                     applied_ff[ch] <= applied_ff[ch] + 8'h01; // [RULE_15]
                  end else if (applied_ff[ch] > target_lvl[ch]) begin
                     applied_ff[ch] <= applied_ff[ch] - 8'h01; // [RULE_15]
                  end
                  state_ff <= AMVC_RAMP_IDLE;
                  wait_ff  <= '0;
               end
               default: begin
                  state_ff <= AMVC_RAMP_IDLE;
               end
            endcase
         end
      end
   end

   assign o_reg_rdata            = reg_rdata_ff;
   assign o_reg_rvalid           = reg_rvalid_ff;
   assign o_left_applied_level   = applied_ff[0];
   assign o_right_applied_level  = applied_ff[1];
   // Below the floor the power stage idles at half duty instead of attenuating
   assign o_left_silenced        = applied_ff[0] < `AMVC_LEVEL_FLOOR; // [RULE_04] [RULE_07]
   assign o_right_silenced       = applied_ff[1] < `AMVC_LEVEL_FLOOR; // [RULE_03] [RULE_07]
   assign o_ramp_busy            = (applied_ff[0] != target_lvl[0])
                                 | (applied_ff[1] != target_lvl[1]);
   assign o_parallel_bridge_mode = amvc_topology_t'(out_stage_ff[`AMVC_OS_BRIDGE_BIT]); // [RULE_08]
   assign o_mono_source_select   = out_stage_ff[`AMVC_OS_MONO_BIT]; // [RULE_12]
   assign o_analog_gain          = out_stage_ff[`AMVC_OS_GAIN_HI:`AMVC_OS_GAIN_LO]; // [RULE_11]
   assign o_switch_rate_code     = out_stage_ff[`AMVC_OS_RATE_HI:`AMVC_OS_RATE_LO];
   assign o_switch_half_multiple = switch_half_ff;

endmodule // amvc_level_output_bank

// File: amvc_consts.svh
// Offsets, field positions, reset values and timing counts of the level and output bank
`ifndef AMVC_CONSTS_SVH
`define AMVC_CONSTS_SVH

`define AMVC_ADDR_W            8
`define AMVC_OFS_RAMP_SILENCE  8'h03
`define AMVC_OFS_LEFT_LEVEL    8'h04
`define AMVC_OFS_RIGHT_LEVEL   8'h05
`define AMVC_OFS_OUT_STAGE     8'h06

`define AMVC_RST_RAMP_SILENCE  8'h80
`define AMVC_RST_LEVEL         8'hcf
`define AMVC_RST_OUT_STAGE     8'h51
`define AMVC_RST_SWITCH_HALF   6'h20
`define AMVC_RS_WR_MASK        8'h83

`define AMVC_RS_RAMP_BIT       7
`define AMVC_RS_SIL_R_BIT      1
`define AMVC_RS_SIL_L_BIT      0

`define AMVC_OS_BRIDGE_BIT     7
`define AMVC_OS_RATE_HI        6
`define AMVC_OS_RATE_LO        4
`define AMVC_OS_GAIN_HI        3
`define AMVC_OS_GAIN_LO        2
`define AMVC_OS_MONO_BIT       1
`define AMVC_OS_RSVD_BIT       0

`define AMVC_GAIN_FORBIDDEN    2'h3
`define AMVC_LEVEL_FLOOR       8'h07
`define AMVC_LEVEL_SILENT      8'h00

// Ramp wait before each step, in ns, and its cycle count at the 10 ns clock; each step adds two cycles more
`define AMVC_CLK_PERIOD_NS     10
`define AMVC_RAMP_STEP_NS      1000
`define AMVC_RAMP_STEP_CYC     (`AMVC_RAMP_STEP_NS / `AMVC_CLK_PERIOD_NS)

`endif

// File: amvc_pkg.sv
// Types shared by the level and output configuration bank
package amvc_pkg;

   typedef enum logic [0:0] {
      AMVC_BRIDGE_TIED   = 1'b0,
      AMVC_PARALLEL_BRIDGE = 1'b1
   } amvc_topology_t;

   typedef enum logic [1:0] {
      AMVC_RAMP_IDLE = 2'b00,
      AMVC_RAMP_WAIT = 2'b01,
      AMVC_RAMP_STEP = 2'b10
   } amvc_ramp_state_t;

endpackage

// File: amvc_level_output_bank_sva.sv
// Concurrent checks on the ports of the level and output bank
`timescale 1ns/1ns
module amvc_level_output_bank_sva
   import amvc_pkg::*;
(
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       o_reg_rvalid,
   input wire logic       i_speed_mode_select,
   input wire logic [7:0] o_left_applied_level,
   input wire logic [7:0] o_right_applied_level,
   input wire logic       o_left_silenced,
   input wire logic       o_right_silenced,
   input amvc_topology_t  o_parallel_bridge_mode,
   input wire logic       o_mono_source_select,
   input wire logic [1:0] o_analog_gain,
   input wire logic [2:0] o_switch_rate_code,
   input wire logic [5:0] o_switch_half_multiple
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_os_wr;
      i_reg_wr && i_reg_addr == 8'h06;
   endsequence
   sequence s_rs_wr;
      i_reg_wr && i_reg_addr == 8'h03;
   endsequence
   function automatic logic [5:0] half_of(input logic [2:0] c, input logic s);
      logic [5:0] m;
      m = (c < 3'h6) ? 6'(6 + 2 * c) : ((c == 3'h6) ? 6'd20 : 6'd24);
      return s ? m : 6'(m << 1);
   endfunction
   AST_RVALID: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe without valid");
   AST_RVALID_ONLY: assert property (!i_reg_rd |=> !o_reg_rvalid)
      else $error("valid without read strobe");
   AST_SIL_L: assert property (o_left_silenced == (o_left_applied_level < 8'h07))
      else $error("left silence flag wrong");
   AST_SIL_R: assert property (o_right_silenced == (o_right_applied_level < 8'h07))
      else $error("right silence flag wrong");
   AST_MUTE_L: assert property (s_rs_wr ##0 (!i_reg_wdata[7] && i_reg_wdata[0]) |-> ##2 o_left_applied_level == 8'h00)
      else $error("left not silenced");
   AST_BRIDGE: assert property (s_os_wr |=> o_parallel_bridge_mode == $past(i_reg_wdata[7]))
      else $error("topology not updated");
   AST_RATE: assert property (s_os_wr |=> o_switch_rate_code == $past(i_reg_wdata[6:4]))
      else $error("rate code not updated");
   AST_GAIN: assert property (s_os_wr ##0 i_reg_wdata[3:2] != 2'h3 |=> o_analog_gain == $past(i_reg_wdata[3:2]))
      else $error("gain not updated");
   AST_MONO: assert property (s_os_wr |=> o_mono_source_select == $past(i_reg_wdata[1]))
      else $error("mono source not updated");
   AST_HALF: assert property ($stable(o_switch_rate_code) && $stable(i_speed_mode_select) |-> o_switch_half_multiple == half_of(o_switch_rate_code, i_speed_mode_select))
      else $error("switching multiple wrong");
endmodule // amvc_level_output_bank_sva

// File: amvc_host_model.sv
// Host side of the register byte port
`timescale 1ns/1ns
module amvc_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic      [7:0] o_reg_wdata
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h03) v[6:2] = 5'h00;
      if (a == 8'h06) v[0] = 1'b1;
      if (a == 8'h06 && v[3:2] == 2'h3) v[3:2] = 2'h0;
      @(posedge i_ref_clk);
      o_reg_addr <= a;
      o_reg_wdata <= v;
      o_reg_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_reg_wr <= 1'b0;
      // Released data line shows no stale value
      o_reg_wdata <= ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic vl);
      @(posedge i_ref_clk);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_ref_clk);
      o_reg_rd <= 1'b0;
      @(posedge i_ref_clk);
      d = i_reg_rdata;
      vl = i_reg_rvalid;
   endtask
endmodule // amvc_host_model

// File: amp_volume_output_config_tb_top.sv
// Self-checking bench of the level and output bank
`timescale 1ns/1ns
module amp_volume_output_config_tb_top;
   import amvc_pkg::*;
   logic clk, rst_n, spd, wr, rd, rv, busy, sl, sr, mono;
   logic [7:0] addr, wd, rdat, al, ar, d, bnd [4];
   logic [7:0] mdl [8];
   logic [1:0] gain;
   logic [2:0] rate;
   logic [5:0] half;
   amvc_topology_t brg;
   logic [31:0] lf;
   int fails, cmp_count, cyc, steps, k, code, o;
   amvc_host_model host (.i_ref_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
      .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wd));
   amvc_level_output_bank #(.RAMP_STEP_CYC(2)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
      .o_reg_rvalid(rv), .i_speed_mode_select(spd), .o_left_applied_level(al),
      .o_right_applied_level(ar), .o_left_silenced(sl), .o_right_silenced(sr),
      .o_ramp_busy(busy), .o_parallel_bridge_mode(brg), .o_mono_source_select(mono),
      .o_analog_gain(gain), .o_switch_rate_code(rate), .o_switch_half_multiple(half));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wrw(input logic [7:0] a, input logic [7:0] v);
      host.wr(a, v);
      // Reference copy of the bank, kept from the rules alone
      if (a == 8'h03) mdl[3] = v & 8'h83;
      if (a == 8'h04 || a == 8'h05) mdl[a[2:0]] = v;
      if (a == 8'h06) mdl[6] = (v[3:2] == 2'h3) ? {v[7:4], mdl[6][3:2], v[1:0]} : v;
      @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x;
      logic vl;
      host.rd(a, x, vl);
      chk("rvalid", {7'h00, vl}, 8'h01);
      chk("rdata", x, e);
      chk("model", x, mdl[a[2:0]]);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (al !== d) steps++;
      d <= al;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      spd = 1'b0;
      lf = 32'h0000_0868;
      bnd = '{8'h06, 8'h07, 8'hff, 8'h00};
      mdl = '{8'h00, 8'h00, 8'h00, 8'h80, 8'hcf, 8'hcf, 8'h51, 8'h00};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(8'h03, 8'h80);
      rd_chk(8'h04, 8'hcf);
      rd_chk(8'h05, 8'hcf);
      rd_chk(8'h06, 8'h51);
      rd_chk(8'h07, 8'h00);
      chk("half", {2'b00, half}, 8'd32);
      wrw(8'h03, 8'h03);
      chk("left", al, 8'h00);
      chk("right", ar, 8'h00);
      chk("silence flags", {6'h00, sr, sl}, 8'h03);
      rd_chk(8'h03, 8'h03);
      wrw(8'h03, 8'h00);
      chk("right back", ar, 8'hcf);
      for (int i = 0; i < 12; i++) begin
         lf = lfsr(lf);
         code = (i < 4) ? bnd[i] : lf[7:0];
         wrw(8'h04 + 8'(i % 2), 8'(code));
         chk("level", (i % 2) ? ar : al, (code < 7) ? 8'h00 : 8'(code));
         chk("silenced", {7'h00, (i % 2) ? sr : sl}, {7'h00, code < 7});
      end
      for (int r = 0; r < 16; r++) begin
         lf = lfsr(lf);
         spd <= r[3];
         o = {lf[7], r[2:0], 2'(lf[9:8] % 3), lf[1], 1'b1};
         wrw(8'h06, 8'(o));
         chk("bridge", {7'h00, brg}, {7'h00, lf[7]});
         chk("mono", {7'h00, mono}, {7'h00, lf[1]});
         chk("rate", {5'h00, rate}, {5'h00, r[2:0]});
         chk("gain", {6'h00, gain}, 8'(o[3:2]));
         k = (r[2:0] < 6) ? 6 + 2 * r[2:0] : ((r[2:0] == 6) ? 20 : 24);
         chk("half", {2'b00, half}, 8'(r[3] ? k : 2 * k));
         rd_chk(8'h06, 8'(o));
      end
      wrw(8'h04, 8'h40);
      wrw(8'h03, 8'h80);
      steps = 0;
      wrw(8'h04, 8'h3c);
      chk("busy", {7'h00, busy}, 8'h01);
      for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
      #1;
      chk("ramp end", al, 8'h3c);
      chk("ramp steps", 8'(steps), 8'd4);
      // Second reset in mid-run must bring every default back
      spd <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      mdl = '{8'h00, 8'h00, 8'h00, 8'h80, 8'hcf, 8'hcf, 8'h51, 8'h00};
      rd_chk(8'h06, 8'h51);
      rd_chk(8'h03, 8'h80);
      chk("left reset", al, 8'hcf);
      chk("right reset", ar, 8'hcf);
      chk("half reset", {2'b00, half}, 8'd32);
      end_of_test();
   end
endmodule // amp_volume_output_config_tb_top
bind amvc_level_output_bank amvc_level_output_bank_sva u_sva (.i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid),
   .i_speed_mode_select(i_speed_mode_select), .o_left_applied_level(o_left_applied_level),
   .o_right_applied_level(o_right_applied_level), .o_left_silenced(o_left_silenced),
   .o_right_silenced(o_right_silenced), .o_parallel_bridge_mode(o_parallel_bridge_mode),
   .o_mono_source_select(o_mono_source_select), .o_analog_gain(o_analog_gain),
   .o_switch_rate_code(o_switch_rate_code), .o_switch_half_multiple(o_switch_half_multiple));
